//--- design/sfd_top.sv
// Purpose: serial flash array command decoder, device side
// Assumes: sclk, cs_n and si are asynchronous pins, sclk well below clock/4
// Notes:   single-bit framing only; program data is not buffered
//
// Summary of operation
// - opcode 02h, three address bytes, one or more data bytes program the page.
// - opcode 20h with three address bytes erases the 4 KB sector.
// - opcode d8h with three address bytes erases the 64 KB block.
// - read dummy cycle count follows config bits 6 and 7; host matches it.
// - program or erase ending off a byte boundary is rejected, not executed.
// - inputs sampled on serial clock rise, outputs shifted on its fall.
// - unknown opcode parks in standby, output off, until chip select rises.
// - array commands are ignored while a program or erase is busy.
`timescale 1ns/1ps
`include "sfd_regs.svh"
module sfd_top
  import sfd_pkg::*;
(
  input  wire logic        i_clock,       // 50 MHz system clock
  input  wire logic        i_sys_rst,     // sync reset, high
  input  wire logic        i_sclk,        // serial clock pin
  input  wire logic        i_cs_n,        // chip select pin, low active
  input  wire logic        i_si,          // serial data in pin
  input  wire logic [7:0]  i_config,      // configuration register value
  input  wire logic        i_array_busy,  // program or erase running
  input  wire logic        i_rd_valid,    // array read byte valid
  input  wire logic [7:0]  i_rd_data,     // array read byte
  output logic             o_rd_ready,    // buffer can take a byte
  output logic             o_rd_active,   // read in progress at o_cmd_addr
  output logic             o_so,          // serial data out
  output logic             o_so_oe,       // serial data out enable
  output logic             o_cmd_go,      // execute command, pulse
  output sfd_cmd_e         o_cmd_kind,    // command kind
  output logic [23:0]      o_cmd_addr,    // command address
  output logic             o_pgm_valid,   // program byte strobe
  output sfd_byte_t        o_pgm_data     // program byte
);

  // ========================================================
  // pin synchronisers
  logic [2:0] sclk_q;
  logic [2:0] cs_q;
  logic [1:0] si_q;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sclk_q <= 3'h0;
      cs_q   <= 3'h7;
      si_q   <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], i_sclk};
      cs_q   <= {cs_q[1:0], i_cs_n};
      si_q   <= {si_q[0], i_si};
    end
  end

  // only the second and third stages feed logic
  wire sclk_rise = sclk_q[1] && !sclk_q[2];
  wire sclk_fall = !sclk_q[1] && sclk_q[2];
  wire cs_fall   = !cs_q[1] && cs_q[2];
  wire cs_rise   = cs_q[1] && !cs_q[2];
  wire cs_active = !cs_q[1];
  wire si_bit    = si_q[1];

  // ========================================================
  // registers
  sfd_state_e  state_q;
  sfd_state_e  state_d;
  logic [2:0]  bit_q;
  sfd_byte_t   shin_q;
  logic [1:0]  abyte_q;
  logic [15:0] addr_q;
  logic [3:0]  dcnt_q;
  logic        fast_q;
  logic [8:0]  pbytes_q;
  logic [2:0]  obit_q;
  sfd_byte_t   out_q;

  sfd_buf_if rbuf ();

  // ========================================================
  // decode
  wire        byte_done = sclk_rise && (bit_q == 3'h7);
  wire [7:0]  byte_in   = {shin_q[6:0], si_bit};
  wire        op_rd     = (byte_in == `SFD_OP_READ);
  wire        op_fr     = (byte_in == `SFD_OP_FAST_READ);
  wire        op_pp     = (byte_in == `SFD_OP_PAGE_PROGRAM);
  wire        op_se     = (byte_in == `SFD_OP_SECTOR_ERASE);
  wire        op_be     = (byte_in == `SFD_OP_BLOCK_ERASE);
  wire        op_known  = op_rd || op_fr || op_pp || op_se || op_be;
  wire        addr_done = byte_done && (abyte_q == `SFD_LAST_ADDR_BYTE);
  wire [1:0]  dsel      = {i_config[`SFD_DUMMY_SEL_HI_BIT], i_config[`SFD_DUMMY_SEL_LO_BIT]};
  wire [3:0]  dummy_len = (dsel == 2'h0) ? `SFD_DUMMY_DC00 :
                          (dsel == 2'h1) ? `SFD_DUMMY_DC01 :
                          (dsel == 2'h2) ? `SFD_DUMMY_DC10 : `SFD_DUMMY_DC11;
  wire        dummy_end = sclk_rise && (dcnt_q == dummy_len - 4'h1);
  wire        pop       = sclk_fall && (state_q == ST_READ) && (obit_q == 3'h0);
  wire [7:0]  next_out  = rbuf.out_valid ? rbuf.out_data : `SFD_EMPTY_FILL;
  wire        aligned   = (bit_q == 3'h0);
  wire        go_ok     = cs_rise && aligned &&
                          (((state_q == ST_PROG) && (pbytes_q != 9'h0)) ||
                           (state_q == ST_ERASE));
  wire        pgm_strobe = byte_done && (state_q == ST_PROG);
  wire        read_ent  = (state_d == ST_READ) || (state_d == ST_DUMMY);
  sfd_cmd_e   op_kind;

  assign op_kind = op_pp ? CMD_PAGE_PROGRAM :
                   op_se ? CMD_SECTOR_ERASE :
                   op_be ? CMD_BLOCK_ERASE  : CMD_READ;

  assign rbuf.in_valid  = i_rd_valid;
  assign rbuf.in_data   = i_rd_data;
  assign rbuf.out_ready = pop;
  assign o_rd_ready     = rbuf.in_ready;

  sfd_buf u_buf (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_flush   (!o_rd_active),
    .bus       (rbuf)
  );

  // ========================================================
  // command sequencer
  always_comb begin
    state_d = state_q;
    if (!cs_active) begin
      state_d = ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE:    if (cs_fall) state_d = ST_OPCODE;
        ST_OPCODE: begin
          if (byte_done) begin
            if (!op_known || i_array_busy) state_d = ST_STANDBY;
            else                           state_d = ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (addr_done) begin
            if (o_cmd_kind == CMD_PAGE_PROGRAM)    state_d = ST_PROG;
            else if (o_cmd_kind != CMD_READ)       state_d = ST_ERASE;
            else if (fast_q)                       state_d = ST_DUMMY;
            else                                   state_d = ST_READ;
          end
        end
        ST_DUMMY:   if (dummy_end) state_d = ST_READ;
        ST_READ:    state_d = ST_READ;
        ST_PROG:    state_d = ST_PROG;
        ST_ERASE:   state_d = ST_ERASE;
        ST_STANDBY: state_d = ST_STANDBY;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) state_q <= ST_IDLE;
    else           state_q <= state_d;
  end

  // ========================================================
  // input shifting, sampled on serial clock rise
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || !cs_active) begin
      bit_q  <= 3'h0;
      shin_q <= 8'h00;
    end else if (sclk_rise) begin
      bit_q  <= bit_q + 3'h1;
      shin_q <= byte_in;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst || state_q != ST_ADDR) abyte_q <= 2'h0;
    else if (byte_done)                  abyte_q <= abyte_q + 2'h1;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst)                              addr_q <= 16'h0000;
    else if (byte_done && state_q == ST_ADDR)   addr_q <= {addr_q[7:0], byte_in};
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst || state_q != ST_DUMMY) dcnt_q <= 4'h0;
    else if (sclk_rise)                   dcnt_q <= dcnt_q + 4'h1;
  end

  // ========================================================
  // command outputs
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_cmd_kind <= CMD_NONE;
      fast_q     <= 1'b0;
      o_cmd_addr <= 24'h000000;
    end else if (byte_done && state_q == ST_OPCODE && op_known) begin
      o_cmd_kind <= op_kind;
      fast_q     <= op_fr;
    end else if (addr_done && state_q == ST_ADDR) begin
      o_cmd_addr <= {addr_q, byte_in};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst || cs_fall)                        pbytes_q <= 9'h000;
    else if (pgm_strobe && pbytes_q != `SFD_PROG_CNT_MAX) pbytes_q <= pbytes_q + 9'h001;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_cmd_go    <= 1'b0;
      o_pgm_valid <= 1'b0;
      o_pgm_data  <= 8'h00;
      o_rd_active <= 1'b0;
    end else begin
      o_cmd_go    <= go_ok;
      o_pgm_valid <= pgm_strobe;
      o_pgm_data  <= pgm_strobe ? byte_in : o_pgm_data;
      o_rd_active <= read_ent;
    end
  end

  // ========================================================
  // output shifting on serial clock fall; empty buffer sends fill
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || state_q != ST_READ) begin
      obit_q <= 3'h0;
      out_q  <= 8'h00;
    end else if (sclk_fall) begin
      obit_q <= obit_q + 3'h1;
      out_q  <= pop ? {next_out[6:0], 1'b0} : {out_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_so    <= 1'b0;
      o_so_oe <= 1'b0;
    end else begin
      o_so    <= pop ? next_out[7] : ((sclk_fall && state_q == ST_READ) ? out_q[7] : o_so);
      o_so_oe <= (state_d == ST_READ);
    end
  end

  // ========================================================
  // assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  property p_prog_nonempty;
    o_cmd_go && o_cmd_kind == CMD_PAGE_PROGRAM |-> pbytes_q != 9'h000;
  endproperty
  property p_pgm_byte;
    pgm_strobe |=> o_pgm_valid && o_pgm_data == $past(byte_in);
  endproperty
  property p_se_decode;
    state_q == ST_OPCODE && byte_done && cs_active && op_se && !i_array_busy
      |=> state_q == ST_ADDR && o_cmd_kind == CMD_SECTOR_ERASE;
  endproperty
  property p_be_decode;
    state_q == ST_OPCODE && byte_done && cs_active && op_be && !i_array_busy
      |=> state_q == ST_ADDR && o_cmd_kind == CMD_BLOCK_ERASE;
  endproperty
  property p_dummy_end;
    state_q == ST_DUMMY && cs_active && dummy_end |=> state_q == ST_READ;
  endproperty
  property p_dummy_hold;
    state_q == ST_DUMMY && cs_active && sclk_rise && dcnt_q < dummy_len - 4'h1
      |=> state_q == ST_DUMMY;
  endproperty
  // stream ends once the host deselects: no fetch and no drive left behind
  property p_read_stream;
    state_q == ST_READ && !cs_active |=> !o_rd_active && !o_so_oe;
  endproperty
  property p_go_aligned;
    o_cmd_go |-> $past(cs_rise) && $past(bit_q) == 3'h0;
  endproperty
  property p_reject;
    cs_rise && bit_q != 3'h0 |=> !o_cmd_go;
  endproperty
  property p_so_on_fall;
    $changed(o_so) |-> $past(sclk_fall);
  endproperty
  property p_standby;
    state_q == ST_STANDBY && cs_active |=> state_q == ST_STANDBY && !o_so_oe ##1 !o_cmd_go;
  endproperty
  property p_busy_ignore;
    state_q == ST_OPCODE && byte_done && cs_active && i_array_busy |=> state_q == ST_STANDBY;
  endproperty

  a_prog_nonempty: assert property (p_prog_nonempty) else $error("empty program executed");
  a_pgm_byte:      assert property (p_pgm_byte) else $error("program byte not passed on");
  a_se_decode:     assert property (p_se_decode) else $error("sector erase not decoded");
  a_be_decode:     assert property (p_be_decode) else $error("block erase not decoded");
  a_dummy_end:     assert property (p_dummy_end) else $error("dummy phase too long");
  a_dummy_hold:    assert property (p_dummy_hold) else $error("dummy phase too short");
  a_read_stream:   assert property (p_read_stream) else $error("read kept after deselect");
  a_go_aligned:    assert property (p_go_aligned) else $error("command run off boundary");
  a_reject:        assert property (p_reject) else $error("misaligned command ran");
  a_so_on_fall:    assert property (p_so_on_fall) else $error("output moved off fall");
  a_standby:       assert property (p_standby) else $error("standby left or driving");
  a_busy_ignore:   assert property (p_busy_ignore) else $error("command taken while busy");

  c_prog:  cover property (o_cmd_go && o_cmd_kind == CMD_PAGE_PROGRAM);
  c_erase: cover property (o_cmd_go && o_cmd_kind == CMD_BLOCK_ERASE);
  c_dread: cover property (state_q == ST_READ && $past(state_q) == ST_DUMMY);
  c_rej:   cover property (cs_rise && bit_q != 3'h0 && state_q == ST_ERASE);

endmodule : sfd_top

//--- design/sfd_regs.svh
// Purpose: constants of the serial flash array command decoder
// Assumes: single-bit serial framing, 24-bit addresses
// Notes:   dummy counts per select code are plain defaults
`ifndef SFD_REGS_SVH
`define SFD_REGS_SVH

// ==========================================================
// opcodes
`define SFD_OP_READ          8'h03
`define SFD_OP_FAST_READ     8'h0b
`define SFD_OP_PAGE_PROGRAM  8'h02
`define SFD_OP_SECTOR_ERASE  8'h20
`define SFD_OP_BLOCK_ERASE   8'hd8

// ==========================================================
// framing and configuration fields
`define SFD_LAST_ADDR_BYTE   2'h2
`define SFD_DUMMY_SEL_LO_BIT 6
`define SFD_DUMMY_SEL_HI_BIT 7
`define SFD_DUMMY_DC00       4'h8
`define SFD_DUMMY_DC01       4'h6
`define SFD_DUMMY_DC10       4'h8
`define SFD_DUMMY_DC11       4'ha
`define SFD_PROG_CNT_MAX     9'h1ff
`define SFD_EMPTY_FILL       8'hff
`define SFD_BUF_FULL         2'h2

`endif

//--- design/sfd_pkg.sv
// Purpose: types of the serial flash array command decoder
// Assumes: nothing
// Notes:   state codes are one-hot
package sfd_pkg;

  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_OPCODE  = 8'h02,
    ST_ADDR    = 8'h04,
    ST_DUMMY   = 8'h08,
    ST_READ    = 8'h10,
    ST_PROG    = 8'h20,
    ST_ERASE   = 8'h40,
    ST_STANDBY = 8'h80
  } sfd_state_e;

  typedef enum logic [2:0] {
    CMD_NONE          = 3'h0,
    CMD_PAGE_PROGRAM  = 3'h1,
    CMD_SECTOR_ERASE  = 3'h2,
    CMD_BLOCK_ERASE   = 3'h3,
    CMD_READ          = 3'h4
  } sfd_cmd_e;

  typedef logic [7:0] sfd_byte_t;

endpackage : sfd_pkg

//--- design/sfd_buf_if.sv
// Purpose: valid/ready carrier between decoder and its read buffer
// Assumes: one clock
// Notes:   store side is the buffer, user side the decoder
`timescale 1ns/1ps
interface sfd_buf_if;
  import sfd_pkg::*;
  logic      in_valid;
  logic      in_ready;
  sfd_byte_t in_data;
  logic      out_valid;
  logic      out_ready;
  sfd_byte_t out_data;
  modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user  (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : sfd_buf_if

//--- design/sfd_buf.sv
// Purpose: two-entry read data buffer
// Assumes: synchronous reset, flush clears contents
// Notes:   in_ready is a register so the top output stays flopped
`timescale 1ns/1ps
`include "sfd_regs.svh"
module sfd_buf
  import sfd_pkg::*;
(
  input  wire logic i_clock,    // system clock
  input  wire logic i_sys_rst,  // sync reset, high
  input  wire logic i_flush,    // drop all entries
  sfd_buf_if.store  bus         // fill and drain sides
);

  sfd_byte_t  mem_q [2];
  logic       wr_q;
  logic       rd_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       rdy_q;

  wire push = bus.in_valid && rdy_q;
  wire pop  = bus.out_valid && bus.out_ready;

  assign cnt_d         = cnt_q + {1'b0, push} - {1'b0, pop};
  assign bus.in_ready  = rdy_q;
  assign bus.out_valid = (cnt_q != 2'h0);
  assign bus.out_data  = mem_q[rd_q];

  // ========================================================
  // pointers and fill level
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || i_flush) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
      rdy_q <= 1'b1;
    end else begin
      wr_q  <= wr_q ^ push;
      rd_q  <= rd_q ^ pop;
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != `SFD_BUF_FULL);
    end
  end

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_q[wr_q] <= bus.in_data;
    end
  end

endmodule : sfd_buf

//--- sim/sfd_host_model.sv
// Purpose: single-bit host controller driving the decoder's serial pins
// Assumes: mode 0, sclk phases of 4 system clocks (160 ns period)
// Notes:   tasks are called by the bench through the instance
`timescale 1ns/1ps
module sfd_host_model (
  input  wire logic i_clock,  // system clock
  input  wire logic i_so,     // device serial out
  input  wire logic i_so_oe,  // device out enable
  output logic      o_sclk,   // serial clock, idles low
  output logic      o_cs_n,   // chip select, low active
  output logic      o_si      // serial data to device
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end

  // released line wanders so stale bits cannot pass for real ones
  always @(posedge i_clock) if (o_cs_n) o_si <= ~o_si;

  // ==========================================================
  // link tasks
  task automatic half();
    repeat (4) @(posedge i_clock);
  endtask : half

  task automatic start();
    @(posedge i_clock);
    o_cs_n <= 1'b0;
    half();
  endtask : start

  // n bits msb first; undriven output reads back unknown
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      o_si <= tx[i];
      half();
      o_sclk <= 1'b1;
      half();
      rx[i] = i_so_oe ? i_so : 1'bx;
      o_sclk <= 1'b0;
    end
  endtask : bits

  task automatic dummies(input int n);
    repeat (n) begin
      half();
      o_sclk <= 1'b1;
      half();
      o_sclk <= 1'b0;
    end
  endtask : dummies

  task automatic stop();
    half();
    o_cs_n <= 1'b1;
    half();
    half();
  endtask : stop
endmodule : sfd_host_model

//--- sim/test_serial_flash_array_command_decoder.sv
// Purpose: self-checking bench of the array command decoder
// Assumes: host model on the pins, array model in this module
// Notes:   expected read bytes follow pat() of the running address
`timescale 1ns/1ps
`include "sfd_regs.svh"
module test_serial_flash_array_command_decoder
  import sfd_pkg::*;
;
  logic        i_clock, i_sys_rst, busy, rd_valid;
  logic [7:0]  cfg, rd_data, junk;
  logic [23:0] ptr, go_addr;
  wire         sclk, cs_n, si, so, so_oe, rd_ready, rd_active, cmd_go, pgm_valid;
  wire [7:0]   pgm_data;
  wire [23:0]  cmd_addr;
  sfd_cmd_e    cmd_kind, go_kind;
  int          fails, compares, go_n, oe_n;
  logic [7:0]  pq[$];

  sfd_top sfd_top_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_si(si), .i_config(cfg), .i_array_busy(busy), .i_rd_valid(rd_valid),
    .i_rd_data(rd_data), .o_rd_ready(rd_ready), .o_rd_active(rd_active), .o_so(so),
    .o_so_oe(so_oe), .o_cmd_go(cmd_go), .o_cmd_kind(cmd_kind), .o_cmd_addr(cmd_addr),
    .o_pgm_valid(pgm_valid), .o_pgm_data(pgm_data));
  sfd_host_model sfd_host_model_inst (.i_clock(i_clock), .i_so(so), .i_so_oe(so_oe),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));

  always #10 i_clock = ~i_clock;

  // ==========================================================
  // array model and monitors
  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : pat

  always @(posedge i_clock) begin
    if (rd_active === 1'b1 && rd_valid !== 1'b1) begin
      ptr      <= cmd_addr;
      rd_data  <= pat(cmd_addr);
      rd_valid <= 1'b1;
    end else if (rd_active === 1'b1 && rd_ready === 1'b1) begin
      ptr     <= ptr + 24'h1;
      rd_data <= pat(ptr + 24'h1);
    end else if (rd_active !== 1'b1) begin
      rd_valid <= 1'b0;
    end
  end

  always @(posedge i_clock) begin
    if (cmd_go === 1'b1) begin
      go_n++;
      go_kind = cmd_kind;
      go_addr = cmd_addr;
    end
    if (pgm_valid === 1'b1) pq.push_back(pgm_data);
    if (so_oe === 1'b1) oe_n++;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic send(input logic [7:0] b);
    sfd_host_model_inst.bits(b, 8, junk);
  endtask : send

  task automatic frame(input logic [7:0] op, input logic [23:0] a);
    go_n = 0;
    oe_n = 0;
    pq.delete();
    sfd_host_model_inst.start();
    send(op);
    send(a[23:16]);
    send(a[15:8]);
    send(a[7:0]);
  endtask : frame

  task automatic close();
    sfd_host_model_inst.stop();
    repeat (12) @(posedge i_clock);
  endtask : close

  // ==========================================================
  // scenarios
  task automatic t_erase(input logic [7:0] op, input sfd_cmd_e k, input logic [23:0] a);
    frame(op, a);
    close();
    check(go_n, 1);
    check(go_kind, k);
    check(go_addr, a);
  endtask : t_erase

  task automatic t_program(input int n, input int tail);
    frame(8'h02, 24'h12ab00);
    for (int k = 0; k < n; k++) send(k[7:0] ^ 8'h3c);
    if (tail > 0) sfd_host_model_inst.bits(8'ha5, tail, junk);
    close();
    check(go_n, (n > 0 && tail == 0) ? 1 : 0);
    check(pq.size(), n);
    for (int k = 0; k < pq.size(); k++) check(pq[k], k[7:0] ^ 8'h3c);
    if (go_n == 1) check({go_kind, go_addr}, {CMD_PAGE_PROGRAM, 24'h12ab00});
  endtask : t_program

  task automatic t_erase_cut(input int tail);
    frame(8'h20, 24'h004000);
    sfd_host_model_inst.bits(8'h00, tail, junk);
    close();
    check(go_n, 0);
  endtask : t_erase_cut

  task automatic t_read(input logic [7:0] op, input logic [1:0] c, input logic [23:0] a);
    int n;
    @(posedge i_clock);
    cfg <= {c, 6'h2a};
    case (c)
      2'h0: n = `SFD_DUMMY_DC00;
      2'h1: n = `SFD_DUMMY_DC01;
      2'h2: n = `SFD_DUMMY_DC10;
      default: n = `SFD_DUMMY_DC11;
    endcase
    frame(op, a);
    if (op == 8'h0b) sfd_host_model_inst.dummies(n);
    for (int k = 0; k < 5; k++) begin
      sfd_host_model_inst.bits(8'hff, 8, junk);
      check(junk, pat(a + k));
    end
    check(rd_active, 1);
    close();
    check(so_oe, 0);
    check(go_n, 0);
  endtask : t_read

  task automatic t_refused();
    @(posedge i_clock);
    busy <= 1'b1;
    t_erase_cut(0);
    frame(8'h0b, 24'h000100);
    sfd_host_model_inst.dummies(8);
    close();
    check(oe_n, 0);
    @(posedge i_clock);
    busy <= 1'b0;
    go_n = 0;
    sfd_host_model_inst.start();
    send(8'h7e);
    send(8'h20);
    send(8'h01);
    send(8'h02);
    send(8'h03);
    close();
    check(go_n + oe_n, 0);
    t_erase(8'h20, CMD_SECTOR_ERASE, 24'h010203);
  endtask : t_refused

  // ==========================================================
  // main sequence and watchdog
  initial begin
    i_clock   = 1'b0;
    i_sys_rst = 1'b1;
    busy      = 1'b0;
    cfg       = 8'h00;
    rd_valid  = 1'b0;
    rd_data   = 8'h00;
    fails     = 0;
    compares  = 0;
    repeat (10) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clock);
    check({rd_ready, so_oe, cmd_go, pgm_valid}, 4'h8);
    check(cmd_kind, CMD_NONE);
    t_erase(8'h20, CMD_SECTOR_ERASE, 24'hfff123);
    t_erase(8'hd8, CMD_BLOCK_ERASE, 24'h7e5a01);
    t_program(1, 0);
    t_program(256, 0);
    t_program(0, 0);
    t_program(2, 3);
    t_erase_cut(5);
    t_erase_cut(1);
    t_read(8'h03, 2'h0, 24'h03fffe);
    for (int c = 0; c < 4; c++) t_read(8'h0b, c[1:0], 24'h20ff00 + c);
    t_refused();
    end_sim();
  end

  initial begin
    repeat (80000) @(posedge i_clock);
    fails++;
    end_sim();
  end
endmodule : test_serial_flash_array_command_decoder
